// ---- logic/uaf_pkg.sv ----
package uaf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FAST_BPS = 4_000_000;
  localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / FAST_BPS);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_BAUD = 8'h04;
  localparam logic [7:0] R_ADDR = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0c;
  localparam logic [7:0] R_MASK = 8'h10;
  localparam logic [7:0] R_TXPTR = 8'h14;
  localparam logic [7:0] R_TXCNT = 8'h18;
  localparam logic [7:0] R_RXPTR = 8'h1c;
  localparam logic [7:0] R_RXCNT = 8'h20;
  localparam logic [7:0] R_STATE = 8'h24;

  localparam int C_EN = 0;
  localparam int C_FLOW = 1;
  localparam int C_PAR = 2;
  localparam int C_ODD = 3;
  localparam int C_STOP2 = 4;
  localparam int C_AMATCH = 5;
  localparam int C_NB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0800;
  localparam logic [15:0] BAUD_RST = 16'h01b2;
  localparam logic [3:0] NB_MIN = 4'h4;
  localparam logic [3:0] NB_MAX = 4'h9;

  localparam int S_TXDONE = 0;
  localparam int S_RXDONE = 1;
  localparam int S_PERR = 2;
  localparam int S_FERR = 3;
  localparam int S_RXCHAR = 4;
  localparam int S_OVR = 5;
  localparam int NST = 6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    B_IDLE = 3'b000,
    B_START = 3'b001,
    B_DATA = 3'b010,
    B_PAR = 3'b011,
    B_STOP = 3'b100
  } uaf_bit_t;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RD = 2'b01,
    D_WR = 2'b10
  } uaf_dma_t;

endpackage

// ---- logic/uaf_tx.sv ----
module uaf_tx (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Frame format
  input wire logic [15:0] div,
  input wire logic [3:0] nb,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic stop2,
  // Character in
  input wire logic go,
  input wire logic [8:0] data,
  output logic busy,
  // Line
  output logic txd
);
  uaf_pkg::uaf_bit_t st;
  logic [15:0] cnt;
  logic [3:0] idx;
  logic [8:0] sh;
  logic par;
  logic second;
  logic tick;

  assign tick = cnt == div - 16'h0001;
  assign busy = st != uaf_pkg::B_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= uaf_pkg::B_IDLE;
      cnt <= 16'h0000;
      idx <= 4'h0;
      sh <= 9'h000;
      par <= 1'b0;
      second <= 1'b0;
      txd <= 1'b1;
    end else begin
      cnt <= (st == uaf_pkg::B_IDLE || tick) ? 16'h0000 : cnt + 16'h0001;
      unique case (st)
        uaf_pkg::B_IDLE: if (go) begin
          sh <= data;
          par <= par_odd;
          idx <= 4'h0;
          txd <= 1'b0;
          st <= uaf_pkg::B_START;
        end
        uaf_pkg::B_START: if (tick) begin
          txd <= sh[0];
          st <= uaf_pkg::B_DATA;
        end
        uaf_pkg::B_DATA: if (tick) begin
          par <= par ^ sh[0];
          sh <= {1'b0, sh[8:1]};
          idx <= idx + 4'h1;
          if (idx == nb - 4'h1) begin
            second <= 1'b0;
            if (par_en) begin
              txd <= par ^ sh[0];
              st <= uaf_pkg::B_PAR;
            end else begin
              txd <= 1'b1;
              st <= uaf_pkg::B_STOP;
            end
          end else begin
            txd <= sh[1];
          end
        end
        uaf_pkg::B_PAR: if (tick) begin
          txd <= 1'b1;
          st <= uaf_pkg::B_STOP;
        end
        uaf_pkg::B_STOP: if (tick) begin
          if (stop2 && !second) second <= 1'b1;
          else st <= uaf_pkg::B_IDLE;
        end
        default: st <= uaf_pkg::B_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tx_idle_high: assert property (st == uaf_pkg::B_IDLE |-> txd)
    else $error("tx line not high while idle");
  a_tx_start_bit: assert property (go && !busy |=> !txd [*8])
    else $error("start bit shorter than expected");
endmodule

// ---- logic/uaf_rx.sv ----
module uaf_rx (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Frame format
  input wire logic [15:0] div,
  input wire logic [3:0] nb,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic stop2,
  // Line, already synchronised
  input wire logic rxd,
  // Character out
  output logic valid,
  output logic [8:0] data,
  output logic pe,
  output logic fe
);
  uaf_pkg::uaf_bit_t st;
  logic [15:0] cnt;
  logic [3:0] idx;
  logic par;
  logic second;
  logic tick;

  assign tick = cnt == div - 16'h0001;

  // Sampling at mid bit keeps the most margin against baud mismatch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= uaf_pkg::B_IDLE;
      cnt <= 16'h0000;
      idx <= 4'h0;
      par <= 1'b0;
      second <= 1'b0;
      valid <= 1'b0;
      data <= 9'h000;
      pe <= 1'b0;
      fe <= 1'b0;
    end else begin
      valid <= 1'b0;
      cnt <= tick ? 16'h0000 : cnt + 16'h0001;
      unique case (st)
        uaf_pkg::B_IDLE: begin
          cnt <= 16'h0000;
          if (!rxd) st <= uaf_pkg::B_START;
        end
        uaf_pkg::B_START: if (cnt == {1'b0, div[15:1]}) begin
          cnt <= 16'h0000;
          if (rxd) st <= uaf_pkg::B_IDLE;
          else begin
            st <= uaf_pkg::B_DATA;
            idx <= 4'h0;
            par <= par_odd;
            data <= 9'h000;
            pe <= 1'b0;
            fe <= 1'b0;
          end
        end
        uaf_pkg::B_DATA: if (tick) begin
          data[idx] <= rxd;
          par <= par ^ rxd;
          idx <= idx + 4'h1;
          second <= 1'b0;
          if (idx == nb - 4'h1) st <= par_en ? uaf_pkg::B_PAR : uaf_pkg::B_STOP;
        end
        uaf_pkg::B_PAR: if (tick) begin
          pe <= par ^ rxd;
          st <= uaf_pkg::B_STOP;
        end
        uaf_pkg::B_STOP: if (tick) begin
          if (!rxd) fe <= 1'b1;
          if (stop2 && !second) second <= 1'b1;
          else begin
            valid <= 1'b1;
            st <= uaf_pkg::B_IDLE;
          end
        end
        default: st <= uaf_pkg::B_IDLE;
      endcase
    end
  end
endmodule

// ---- logic/uaf_top.sv ----
// The AHB-Lite register port and the register offsets are this design's own decisions.
module uaf_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // DMA memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // Serial pins
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  // Interrupt
  output logic irq
);
  logic acc;
  logic ap_wr;
  logic ap_rd;
  logic [7:0] ap_a;
  logic [31:0] next_rdata;
  logic [31:0] ctrl;
  logic [15:0] baud;
  logic [7:0] addr_m;
  logic [5:0] status;
  logic [5:0] mask;
  logic [5:0] ev;
  logic [5:0] clr;
  logic [31:0] txptr;
  logic [31:0] rxptr;
  logic [15:0] txcnt;
  logic [15:0] rxcnt;
  logic [8:0] tx_buf;
  logic [8:0] rx_buf;
  logic tx_full;
  logic rx_full;
  logic sel_ok;
  logic en;
  logic flow;
  logic [15:0] div;
  logic [3:0] nb;
  logic [1:0] pin_raw;
  logic [1:0] pin_f;
  logic cts_ok;
  logic rx_line;
  logic tx_busy;
  logic tx_busy_q;
  logic tx_go;
  logic rx_v;
  logic [8:0] rx_d;
  logic rx_pe;
  logic rx_fe;
  logic addr_frm;
  logic rx_ok;
  logic rx_take;
  logic ovr;
  logic rd_ack;
  logic wr_ack;
  uaf_pkg::uaf_dma_t dst;

  function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes take no wait, reads take one so that the data is
  // taken from a flip-flop after any preceding write has landed.
  assign acc = hsel && hready && htrans[1];
  assign hreadyout = !ap_rd;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_a <= 8'h00;
    end else begin
      ap_wr <= acc && hwrite && (hsize == 3'h2);
      ap_rd <= acc && !hwrite;
      if (acc) ap_a <= haddr[7:0];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (ap_a)
      uaf_pkg::R_CTRL: next_rdata = ctrl;
      uaf_pkg::R_BAUD: next_rdata = {16'h0000, baud};
      uaf_pkg::R_ADDR: next_rdata = {24'h00_0000, addr_m};
      uaf_pkg::R_STAT: next_rdata = {26'h000_0000, status};
      uaf_pkg::R_MASK: next_rdata = {26'h000_0000, mask};
      uaf_pkg::R_TXPTR: next_rdata = txptr;
      uaf_pkg::R_TXCNT: next_rdata = {16'h0000, txcnt};
      uaf_pkg::R_RXPTR: next_rdata = rxptr;
      uaf_pkg::R_RXCNT: next_rdata = {16'h0000, rxcnt};
      uaf_pkg::R_STATE: next_rdata = {22'h00_0000, tx_busy, tx_full, rx_full, cts_ok,
                                      !rts_n, sel_ok, 2'(dst), 2'h0};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (ap_rd) hrdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= uaf_pkg::CTRL_RST;
      baud <= uaf_pkg::BAUD_RST;
      addr_m <= 8'h00;
      mask <= 6'h00;
    end else begin
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_CTRL)) ctrl <= hwdata & 32'h0000_0f3f;
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_BAUD)) baud <= hwdata[15:0];
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_ADDR)) addr_m <= hwdata[7:0];
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_MASK)) mask <= hwdata[5:0];
    end
  end

  assign en = ctrl[uaf_pkg::C_EN];
  assign flow = ctrl[uaf_pkg::C_FLOW];
  // A divisor below the fast limit would outrun the partner
  assign div = (baud < uaf_pkg::DIV_MIN) ? uaf_pkg::DIV_MIN : baud;

  always_comb begin
    nb = ctrl[uaf_pkg::C_NB +: 4];
    if (nb < uaf_pkg::NB_MIN) nb = uaf_pkg::NB_MIN;
    if (nb > uaf_pkg::NB_MAX) nb = uaf_pkg::NB_MAX;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and
  // three agree, which also rejects a one-cycle glitch.
  assign pin_raw = {cts_n, rxd};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic [2:0] sy;
    logic f;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sy <= 3'h7;
        f <= 1'b1;
      end else begin
        sy <= {sy[1:0], pin_raw[i]};
        if (sy[1] == sy[2]) f <= sy[2];
      end
    end
    assign pin_f[i] = f;
  end

  assign cts_ok = !pin_f[1];
  assign rx_line = pin_f[0];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path; clear-to-send is checked only before a frame starts,
  // so a frame in flight always completes and the line then idles high.
  assign tx_go = tx_full && !tx_busy && en && (!flow || cts_ok);

  uaf_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .div(div),
    .nb(nb),
    .par_en(ctrl[uaf_pkg::C_PAR]),
    .par_odd(ctrl[uaf_pkg::C_ODD]),
    .stop2(ctrl[uaf_pkg::C_STOP2]),
    .go(tx_go),
    .data(tx_buf),
    .busy(tx_busy),
    .txd(txd)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf <= 9'h000;
      tx_full <= 1'b0;
      tx_busy_q <= 1'b0;
    end else begin
      tx_busy_q <= tx_busy;
      if (rd_ack) begin
        tx_buf <= mem_rdata[8:0];
        tx_full <= 1'b1;
      end else if (tx_go) begin
        tx_full <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  uaf_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .div(div),
    .nb(nb),
    .par_en(ctrl[uaf_pkg::C_PAR]),
    .par_odd(ctrl[uaf_pkg::C_ODD]),
    .stop2(ctrl[uaf_pkg::C_STOP2]),
    .rxd(rx_line),
    .valid(rx_v),
    .data(rx_d),
    .pe(rx_pe),
    .fe(rx_fe)
  );

  assign addr_frm = ctrl[uaf_pkg::C_AMATCH] && (nb == uaf_pkg::NB_MAX) && rx_d[8];
  assign rx_ok = !addr_frm && (!ctrl[uaf_pkg::C_AMATCH] || nb != uaf_pkg::NB_MAX || sel_ok);
  assign rx_take = rx_v && rx_ok && en && (rxcnt != 16'h0000) && !rx_full;
  assign ovr = rx_v && rx_ok && !rx_take;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sel_ok <= 1'b0;
    else if (rx_v && addr_frm) sel_ok <= rx_d[7:0] == addr_m;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf <= 9'h000;
      rx_full <= 1'b0;
    end else if (rx_take) begin
      rx_buf <= rx_d;
      rx_full <= 1'b1;
    end else if (wr_ack) begin
      rx_full <= 1'b0;
    end
  end

  // Asserted only while a slot is free; the partner may finish one frame
  // after the drop, which is why the buffer is emptied at once by DMA.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rts_n <= 1'b1;
    else rts_n <= !(en && flow && (rxcnt != 16'h0000) && !rx_full);
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA engine: one request at a time, receive has priority so that
  // incoming characters wait at most for a fetch already under way.
  assign mem_req = dst != uaf_pkg::D_IDLE;
  assign rd_ack = (dst == uaf_pkg::D_RD) && mem_ack;
  assign wr_ack = (dst == uaf_pkg::D_WR) && mem_ack;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dst <= uaf_pkg::D_IDLE;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      unique case (dst)
        uaf_pkg::D_IDLE: begin
          if (rx_full) begin
            dst <= uaf_pkg::D_WR;
            mem_we <= 1'b1;
            mem_addr <= rxptr;
            mem_wdata <= {23'h00_0000, rx_buf};
          end else if (en && txcnt != 16'h0000 && !tx_full) begin
            dst <= uaf_pkg::D_RD;
            mem_we <= 1'b0;
            mem_addr <= txptr;
          end
        end
        uaf_pkg::D_RD, uaf_pkg::D_WR: if (mem_ack) dst <= uaf_pkg::D_IDLE;
        default: dst <= uaf_pkg::D_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txptr <= 32'h0000_0000;
      txcnt <= 16'h0000;
    end else begin
      if (rd_ack) begin
        txptr <= txptr + 32'h0000_0004;
        txcnt <= txcnt - 16'h0001;
      end
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_TXPTR)) txptr <= hwdata;
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_TXCNT)) txcnt <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxptr <= 32'h0000_0000;
      rxcnt <= 16'h0000;
    end else begin
      if (wr_ack) begin
        rxptr <= rxptr + 32'h0000_0004;
        rxcnt <= rxcnt - 16'h0001;
      end
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_RXPTR)) rxptr <= hwdata;
      if (wr_hit(ap_wr, ap_a, uaf_pkg::R_RXCNT)) rxcnt <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt; a new event wins over a clear in the same cycle
  always_comb begin
    ev = 6'h00;
    ev[uaf_pkg::S_TXDONE] = tx_busy_q && !tx_busy && txcnt == 16'h0000 && !tx_full
                            && dst != uaf_pkg::D_RD;
    ev[uaf_pkg::S_RXDONE] = wr_ack && rxcnt == 16'h0001;
    ev[uaf_pkg::S_PERR] = rx_v && rx_pe;
    ev[uaf_pkg::S_FERR] = rx_v && rx_fe;
    ev[uaf_pkg::S_RXCHAR] = rx_take;
    ev[uaf_pkg::S_OVR] = ovr;
  end

  assign clr = wr_hit(ap_wr, ap_a, uaf_pkg::R_STAT) ? hwdata[5:0] : 6'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) status <= 6'h00;
    else status <= (status & ~clr) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq <= 1'b0;
    else irq <= |(status & mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_cts_gate: assert property (tx_go |-> en && (!flow || cts_ok))
    else $error("frame started without clear-to-send");
  a_noflow_ign: assert property (!flow && en && tx_full && !tx_busy |-> tx_go)
    else $error("flow lines not ignored");
  a_rts_off: assert property (!flow |=> rts_n)
    else $error("request-to-send asserted without flow control");
  a_rts_full: assert property (rx_full |=> rts_n)
    else $error("request-to-send asserted with full buffer");
  a_div_min: assert property ($changed(baud) |=> div >= uaf_pkg::DIV_MIN)
    else $error("divisor below fast limit");
  a_dma_fetch: assert property (rd_ack && !wr_hit(ap_wr, ap_a, uaf_pkg::R_TXCNT)
    |=> txcnt == $past(txcnt) - 16'h0001 && tx_full)
    else $error("fetch did not advance count");
  a_dma_store: assert property (rx_full && dst == uaf_pkg::D_IDLE |=> mem_req && mem_we)
    else $error("received character not stored");
  a_addr_drop: assert property (rx_v && addr_frm |=> !$rose(rx_full))
    else $error("address frame stored");
  a_ferr_flag: assert property (rx_v && rx_fe |=> status[uaf_pkg::S_FERR])
    else $error("stop error not flagged");

  c_flow_tx: cover property (flow && tx_go);
  c_rx_perr: cover property (rx_v && rx_pe);
  c_irq: cover property ($rose(irq));
endmodule

// ---- test/uaf_partner.sv ----
module uaf_partner (
  // Clock
  input wire logic hclk,
  // Frame format and clear-to-send hold
  input wire logic [3:0] nb,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic stop2,
  input wire logic hold,
  // Line
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 12;
  logic [8:0] got;
  logic gpar;
  logic fr_ok;
  int frames = 0;
  initial rxd = 1'b1;
  assign cts_n = hold;
  //////////////////////////////
  // Samples mid-bit at the clamped divisor, so a wrong bit time shows up
  always begin
    @(negedge txd);
    repeat (DIV / 2) @(posedge hclk);
    fr_ok = !txd;
    got = '0;
    for (int i = 0; i < nb; i++) begin
      repeat (DIV) @(posedge hclk);
      got[i] = txd;
    end
    gpar = 1'b0;
    if (par_en) begin
      repeat (DIV) @(posedge hclk);
      gpar = txd;
    end
    for (int i = 0; i <= int'(stop2); i++) begin
      repeat (DIV) @(posedge hclk);
      fr_ok &= txd;
    end
    frames++;
  end
  //////////////////////////////
  task automatic send(input logic [8:0] d, input logic bad_par, input logic bad_stop);
    logic p;
    p = par_odd ^ bad_par;
    rxd <= 1'b0;
    repeat (DIV) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      p ^= d[i];
      repeat (DIV) @(posedge hclk);
    end
    if (par_en) begin
      rxd <= p;
      repeat (DIV) @(posedge hclk);
    end
    rxd <= !bad_stop;
    repeat (DIV) @(posedge hclk);
    rxd <= 1'b1;
    repeat (stop2 ? 3 * DIV : 2 * DIV) @(posedge hclk);
  endtask
endmodule

// ---- test/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mem_ack = 0, hold = 0;
  logic [31:0] haddr = 0, hwdata = 0, mem_rdata = 0, hrdata, mem_addr, mem_wdata;
  logic [31:0] wr_addr, wr_data;
  logic [1:0] htrans = 0;
  logic [3:0] nb = 4'h8;
  logic par_en = 0, par_odd = 0, stop2 = 0;
  logic hreadyout, hresp, mem_req, mem_we, txd, rxd, rts_n, cts_n, irq;
  logic [8:0] tx_char = 0;
  int error_cnt = 0, check_count = 0, wr_cnt = 0, irq_cnt = 0;
  uaf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .irq(irq));
  uaf_partner far (.hclk(hclk), .nb(nb), .par_en(par_en), .par_odd(par_odd),
    .stop2(stop2), .hold(hold), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  always #10 hclk = ~hclk;
  //////////////////////////////
  // Memory answers one cycle late, so the request must be held until ack
  always @(posedge hclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= {23'h0, tx_char};
    if (irq === 1'b1) irq_cnt++;
    if (mem_req && mem_ack && mem_we) begin
      wr_cnt++;
      wr_addr = mem_addr;
      wr_data = mem_wdata;
    end
  end
  //////////////////////////////
  task automatic final_report;
    $display("checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic step(output logic [31:0] d);
    logic r;
    int n;
    n = 0;
    // Ready and read data are taken at the rising edge itself, before it updates them
    do begin
      @(posedge hclk);
      r = hreadyout;
      d = hrdata;
      n++;
    end while (r !== 1'b1 && n < 40);
    if (r !== 1'b1) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    step(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    step(rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask
  task automatic wait_cnt(ref int c, input int t);
    int n;
    n = 0;
    while (c < t && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (c < t) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic cfg(input logic [31:0] c);
    nb <= c[11:8];
    par_en <= c[2];
    par_odd <= c[3];
    stop2 <= c[4];
    wr(uaf_pkg::R_CTRL, c);
  endtask
  //////////////////////////////
  task automatic t_reset;
    chk("txd idle", 32'h1, txd);
    chk("rts_n idle", 32'h1, rts_n);
    chk("irq idle", 32'h0, irq);
    chk("hresp okay", 32'h0, hresp);
    rd_chk("ctrl", uaf_pkg::R_CTRL, uaf_pkg::CTRL_RST);
    rd_chk("baud", uaf_pkg::R_BAUD, {16'h0, uaf_pkg::BAUD_RST});
    wr(8'h3c, 32'hffff_ffff);
    rd_chk("unmapped", 8'h3c, 32'h0);
    wr(uaf_pkg::R_BAUD, 32'h0);
  endtask
  task automatic t_tx(input logic [31:0] c, input logic [8:0] ch);
    logic p;
    int f;
    f = far.frames;
    p = c[3];
    for (int i = 0; i < c[11:8]; i++) p ^= ch[i];
    tx_char <= ch;
    cfg(c);
    wr(uaf_pkg::R_MASK, 32'h1);
    wr(uaf_pkg::R_TXPTR, 32'h0);
    wr(uaf_pkg::R_TXCNT, 32'h1);
    wait_cnt(far.frames, f + 1);
    chk("tx data", {23'h0, ch}, {23'h0, far.got});
    chk("tx parity", {31'h0, p & c[2]}, {31'h0, far.gpar});
    chk("tx framing", 32'h1, {31'h0, far.fr_ok});
    wait_cnt(irq_cnt, irq_cnt + 1);
    rd_chk("tx status", uaf_pkg::R_STAT, 32'h1);
    wr(uaf_pkg::R_STAT, 32'h1);
    @(posedge hclk);
    @(negedge hclk);
    chk("irq cleared", 32'h0, irq);
  endtask
  task automatic t_flow;
    int f;
    f = far.frames;
    hold <= 1'b1;
    cfg(32'h0000_0803);
    wr(uaf_pkg::R_RXCNT, 32'h4);
    tx_char <= 9'h055;
    wr(uaf_pkg::R_TXCNT, 32'h1);
    // Blocked for longer than one frame would take
    repeat (200) @(posedge hclk);
    chk("blocked frames", f, far.frames);
    chk("idle txd", 32'h1, txd);
    chk("rts_n on", 32'h0, rts_n);
    hold <= 1'b0;
    wait_cnt(far.frames, f + 1);
    chk("flow data", 32'h55, {23'h0, far.got});
    hold <= 1'b1;
    cfg(32'h0000_0801);
    wr(uaf_pkg::R_TXCNT, 32'h1);
    wait_cnt(far.frames, f + 2);
    chk("rts_n off", 32'h1, rts_n);
  endtask
  task automatic t_rx;
    logic [8:0] ch[3] = '{9'h03c, 9'h05a, 9'h081};
    logic [31:0] st[3] = '{32'h14, 32'h18, 32'h12};
    int w;
    cfg(32'h0000_0805);
    wr(uaf_pkg::R_MASK, 32'h0c);
    wr(uaf_pkg::R_RXPTR, 32'h40);
    wr(uaf_pkg::R_RXCNT, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(uaf_pkg::R_STAT, 32'h3f);
      // The store lands during the idle tail of the frame, before send returns
      w = wr_cnt;
      far.send(ch[i], i == 0, i == 1);
      wait_cnt(wr_cnt, w + 1);
      chk("rx data", {23'h0, ch[i]}, wr_data);
      chk("rx addr", 32'h40 + 4 * i, wr_addr);
      rd_chk("rx status", uaf_pkg::R_STAT, st[i]);
      chk("rx irq", {31'h0, i < 2}, irq);
    end
  endtask
  task automatic t_addr;
    int w;
    w = wr_cnt;
    cfg(32'h0000_0921);
    wr(uaf_pkg::R_ADDR, 32'h12);
    wr(uaf_pkg::R_RXPTR, 32'h80);
    wr(uaf_pkg::R_RXCNT, 32'h4);
    far.send(9'h112, 1'b0, 1'b0);
    far.send(9'h077, 1'b0, 1'b0);
    far.send(9'h113, 1'b0, 1'b0);
    far.send(9'h066, 1'b0, 1'b0);
    far.send(9'h112, 1'b0, 1'b0);
    far.send(9'h099, 1'b0, 1'b0);
    wait_cnt(wr_cnt, w + 2);
    repeat (10) @(posedge hclk);
    chk("stored count", w + 2, wr_cnt);
    chk("match data", 32'h99, wr_data);
    chk("match addr", 32'h84, wr_addr);
  endtask
  //////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_tx(32'h0000_0815, 9'h0a5);
    t_tx(32'h0000_0401, 9'h00b);
    t_tx(32'h0000_090d, 9'h1c6);
    t_flow();
    t_rx();
    t_addr();
    final_report();
  end
endmodule
